// File: rtl/fieldbus_record_pkg.sv
// constants shared by the fieldbus record access block
package fieldbus_record_pkg;

    // register numbers as seen in the record index space
    localparam logic [15:0] REMOTE_STATE_ADDR     = 16'h0192;
    localparam logic [15:0] CURRENT_SETPOINT_ADDR = 16'h01f5;
    localparam logic [15:0] MEASURED_VOLTAGE_ADDR = 16'h01fb;
    // the measured triplet sits in ascending, adjacent registers
    localparam logic [15:0] MEASURED_CURRENT_ADDR = 16'h01fc;
    localparam logic [15:0] MEASURED_POWER_ADDR   = 16'h01fd;

    // control words accepted by the remote state register
    localparam logic [15:0] REMOTE_ENTER_CODE     = 16'hff00;
    localparam logic [15:0] REMOTE_LEAVE_CODE     = 16'h0000;

    // set current scale: full range equals 100 percent of nominal
    localparam logic [15:0] SETPOINT_MAX          = 16'hcccc;

    // values after reset, and the word read from an unmapped register
    localparam logic [15:0] SETPOINT_RESET        = 16'h0000;
    localparam logic        REMOTE_RESET          = 1'b0;
    localparam logic [15:0] READ_DATA_RESET       = 16'h0000;
    localparam logic [15:0] UNMAPPED_READ_VALUE   = 16'h0000;

    // record data carries two bytes per register
    localparam logic [7:0]  BYTES_PER_REG         = 8'h02;

    // read sequencer states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_READ = 2'b10
    } seq_state_type;

endpackage

// File: rtl/register_readback.sv
// readback selection of one record register by its number
`timescale 1ns/10ps
module register_readback
    import fieldbus_record_pkg::*;
(
    input  wire logic [15:0] addr_i,
    input  wire logic        remote_active_i,
    input  wire logic [15:0] setpoint_i,
    input  wire logic [15:0] voltage_i,
    input  wire logic [15:0] current_i,
    input  wire logic [15:0] power_i,
    output wire logic [15:0] data_o,
    output wire logic        hit_o
);

    // address decode, one wire per register
    wire logic hit_remote  = (addr_i == REMOTE_STATE_ADDR);
    wire logic hit_setp    = (addr_i == CURRENT_SETPOINT_ADDR);
    wire logic hit_volt    = (addr_i == MEASURED_VOLTAGE_ADDR);
    wire logic hit_curr    = (addr_i == MEASURED_CURRENT_ADDR);
    wire logic hit_pow     = (addr_i == MEASURED_POWER_ADDR);

    // remote state reads back as the code that would select it
    wire logic [15:0] remote_word = remote_active_i ? REMOTE_ENTER_CODE
                                                    : REMOTE_LEAVE_CODE;

    // unmapped numbers read as a fixed word and are flagged
    assign data_o = hit_remote ? remote_word :
                    hit_setp   ? setpoint_i  :
                    hit_volt   ? voltage_i   :
                    hit_curr   ? current_i   :
                    hit_pow    ? power_i     : UNMAPPED_READ_VALUE;
    assign hit_o  = hit_remote | hit_setp | hit_volt | hit_curr | hit_pow;

endmodule

// File: rtl/fieldbus_record_access.sv
// acyclic record read and write interpreter for the power stage
`timescale 1ns/10ps

// Summary of operation
// - start in local control after reset
// - enter request refused while refuse input set
// - 0xff00 enters remote, 0x0000 leaves it
// - setting writes act only in remote control
// - reads served in any control state
// - set current limited to 0x0000..0xcccc
// - one register equals two record bytes
// - longer reads return ascending consecutive registers
// - voltage, current, power read as triplet
// - voltage register directly below current register
// - accepted set current drives limit immediately
module fieldbus_record_access
    import fieldbus_record_pkg::*;
#(
    parameter int LEN_W = 8
)
(
    input  wire logic             clock_i,
    input  wire logic             resetn_i,
    // request side, one record request per accepted cycle
    input  wire logic             req_valid_i,
    input  wire logic             req_write_i,
    input  wire logic [15:0]      req_addr_i,
    input  wire logic [LEN_W-1:0] record_length_i,
    input  wire logic [15:0]      req_data_i,
    output wire logic             req_ready_o,
    // write answer
    output wire logic             wr_done_o,
    output wire logic             wr_accepted_o,
    // read answer, one 16-bit register per cycle
    output wire logic             rd_valid_o,
    output wire logic [15:0]      rd_data_o,
    output wire logic             rd_last_o,
    output wire logic             rd_unmapped_o,
    // device side
    input  wire logic             remote_refuse_i,
    input  wire logic [15:0]      meas_voltage_i,
    input  wire logic [15:0]      meas_current_i,
    input  wire logic [15:0]      meas_power_i,
    output wire logic             remote_active_o,
    output wire logic [15:0]      current_limit_o
);

    // how the block behaves, as seen from the record request side:
    // - one request is taken at a rising edge where valid and ready
    //   are both high; ready is a flop, so it drops one cycle after
    //   a read is taken and comes back with the last read word
    // - writes never drop ready, so they may follow every cycle
    // - a write answers with a done pulse one cycle after the taking
    //   edge; the accepted pulse beside it tells whether it acted
    // - the remote state and the stored set current change at that
    //   same taking edge, so the answer and the new state agree
    // - a set current write is checked against the remote state as
    //   it stood before the taking edge; an enter and a set current
    //   can therefore not take effect in one and the same cycle
    // - reads are served in local control as well as in remote
    //   control, and never touch the remote state or the setpoint
    // - a read returns one word per cycle, the first one two cycles
    //   after the taking edge, in ascending register order
    // - the measured words are frozen at the taking edge; a burst
    //   over voltage, current and power thus belongs to one instant,
    //   at the cost of being up to one burst old when it arrives
    // - an unmapped register number reads as a fixed word and is
    //   flagged, so the master can tell a gap from a real zero
    // limitation: writes always carry exactly one register; a write
    // of any other length is answered but has no effect
    // limitation: the slot and index arithmetic is the master's job;
    // the request already carries the plain register number
    // hazard: a set current above full scale is dropped, not clamped,
    // so a bad translation on the master side cannot raise the limit

    // words of one read burst, counted at the length width
    localparam logic [LEN_W-1:0] ONE_WORD = LEN_W'(1);
    localparam logic [LEN_W-1:0] NO_WORD  = LEN_W'(0);

    seq_state_type    state_q;
    seq_state_type    state_d;
    logic             ready_q;
    logic             remote_q;
    logic             remote_d;
    logic [15:0]      setpoint_q;
    logic [15:0]      setpoint_d;
    logic             wr_done_q;
    logic             wr_accepted_q;
    logic             rd_valid_q;
    logic [15:0]      rd_data_q;
    logic             rd_last_q;
    logic             rd_unmapped_q;
    logic [15:0]      addr_q;
    logic [15:0]      addr_d;
    logic [LEN_W-1:0] words_left_q;
    logic [LEN_W-1:0] words_left_d;
    logic [15:0]      volt_snap_q;
    logic [15:0]      curr_snap_q;
    logic [15:0]      pow_snap_q;

    wire logic [15:0] sel_data;
    wire logic        sel_hit;

    // request acceptance: only while the sequencer is idle
    wire logic take     = req_valid_i & ready_q;
    wire logic take_wr  = take & req_write_i;
    wire logic take_rd  = take & ~req_write_i;

    // a write must carry exactly one register of data
    wire logic len_one  = (record_length_i == LEN_W'(BYTES_PER_REG));

    // remote state register decode
    wire logic wr_remote = take_wr & len_one
                           & (req_addr_i == REMOTE_STATE_ADDR);
    wire logic enter_req = wr_remote
                           & (req_data_i == REMOTE_ENTER_CODE);
    wire logic leave_req = wr_remote
                           & (req_data_i == REMOTE_LEAVE_CODE);
    // refusal leaves the device where it was, local or remote
    wire logic enter_ok  = enter_req & ~remote_refuse_i;

    // set current decode: gated by remote state and by range
    wire logic wr_setp   = take_wr & len_one
                           & (req_addr_i == CURRENT_SETPOINT_ADDR);
    wire logic in_range  = (req_data_i <= SETPOINT_MAX);
    wire logic setp_ok   = wr_setp & remote_q & in_range;

    wire logic wr_accept = enter_ok | leave_req | setp_ok;

    // read burst length: whole registers, an odd byte is dropped,
    // and a length below one register still returns one word
    wire logic [LEN_W-1:0] req_words = record_length_i >> 1;
    wire logic [LEN_W-1:0] burst_words =
        (req_words == NO_WORD) ? ONE_WORD : req_words;

    wire logic reading   = (state_q == ST_READ);
    wire logic last_word = (words_left_q == ONE_WORD);

    // readback selection works on the snapshot, so a burst over
    // the measured triplet stays coherent even while values move
    register_readback u_readback (
        .addr_i          (addr_q),
        .remote_active_i (remote_q),
        .setpoint_i      (setpoint_q),
        .voltage_i       (volt_snap_q),
        .current_i       (curr_snap_q),
        .power_i         (pow_snap_q),
        .data_o          (sel_data),
        .hit_o           (sel_hit)
    );

    // remote control state: a leave always wins, an enter may be refused
    always_comb begin
        remote_d = remote_q;
        if (leave_req) begin
            remote_d = 1'b0;
        end else if (enter_ok) begin
            remote_d = 1'b1;
        end
    end

    // set current store; a refused write changes nothing
    always_comb begin
        setpoint_d = setpoint_q;
        if (setp_ok) begin
            setpoint_d = req_data_i;
        end
    end

    // read sequencer: reads never look at the remote state
    always_comb begin
        state_d      = state_q;
        addr_d       = addr_q;
        words_left_d = words_left_q;
        unique case (state_q)
            ST_IDLE: begin
                if (take_rd) begin
                    state_d      = ST_READ;
                    addr_d       = req_addr_i;
                    words_left_d = burst_words;
                end
            end
            ST_READ: begin
                // step to the next register number, ascending
                // current follows voltage, so one step reaches it
                addr_d       = addr_q + 16'h0001;
                words_left_d = words_left_q - ONE_WORD;
                if (last_word) begin
                    state_d = ST_IDLE;
                end
            end
        endcase
    end

    // control state registers
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            state_q      <= ST_IDLE;
            ready_q      <= 1'b1;
            remote_q     <= REMOTE_RESET;
            setpoint_q   <= SETPOINT_RESET;
            addr_q       <= 16'h0000;
            words_left_q <= NO_WORD;
        end else begin
            state_q      <= state_d;
            ready_q      <= (state_d == ST_IDLE);
            remote_q     <= remote_d;
            setpoint_q   <= setpoint_d;
            addr_q       <= addr_d;
            words_left_q <= words_left_d;
        end
    end

    // measured values are sampled once when a read is taken
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            volt_snap_q <= 16'h0000;
            curr_snap_q <= 16'h0000;
            pow_snap_q  <= 16'h0000;
        end else if (take_rd) begin
            volt_snap_q <= meas_voltage_i;
            curr_snap_q <= meas_current_i;
            pow_snap_q  <= meas_power_i;
        end
    end

    // write answer, one cycle after the request is taken
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            wr_done_q     <= 1'b0;
            wr_accepted_q <= 1'b0;
        end else begin
            wr_done_q     <= take_wr;
            wr_accepted_q <= take_wr & wr_accept;
        end
    end

    // read answer stream; the first word is the addressed register
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            rd_valid_q    <= 1'b0;
            rd_data_q     <= READ_DATA_RESET;
            rd_last_q     <= 1'b0;
            rd_unmapped_q <= 1'b0;
        end else begin
            rd_valid_q    <= reading;
            rd_data_q     <= reading ? sel_data : READ_DATA_RESET;
            rd_last_q     <= reading & last_word;
            rd_unmapped_q <= reading & ~sel_hit;
        end
    end

    // every output is a flop; the limit follows the store directly
    assign req_ready_o     = ready_q;
    assign wr_done_o       = wr_done_q;
    assign wr_accepted_o   = wr_accepted_q;
    assign rd_valid_o      = rd_valid_q;
    assign rd_data_o       = rd_data_q;
    assign rd_last_o       = rd_last_q;
    assign rd_unmapped_o   = rd_unmapped_q;
    assign remote_active_o = remote_q;
    assign current_limit_o = setpoint_q;

endmodule

// File: testbench/record_access_chk.sv
// port assertions for the record access block
`timescale 1ns/10ps
module record_access_chk
    import fieldbus_record_pkg::*;
#(
    parameter int LEN_W = 8
)
(
    input  wire logic             clock_i,
    input  wire logic             resetn_i,
    input  wire logic             req_valid_i,
    input  wire logic             req_write_i,
    input  wire logic [15:0]      req_addr_i,
    input  wire logic [LEN_W-1:0] record_length_i,
    input  wire logic [15:0]      req_data_i,
    input  wire logic             req_ready_o,
    input  wire logic             wr_accepted_o,
    input  wire logic             rd_valid_o,
    input  wire logic [15:0]      rd_data_o,
    input  wire logic             rd_last_o,
    input  wire logic             remote_refuse_i,
    input  wire logic [15:0]      meas_voltage_i,
    input  wire logic [15:0]      meas_current_i,
    input  wire logic [15:0]      meas_power_i,
    input  wire logic             remote_active_o,
    input  wire logic [15:0]      current_limit_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // taken requests decoded once for all properties
    wire logic take_rd = req_valid_i && req_ready_o && !req_write_i;
    wire logic take_wr = req_valid_i && req_ready_o && req_write_i;
    wire logic two     = record_length_i == LEN_W'(2);
    wire logic rem_wr  = take_wr && two && req_addr_i == REMOTE_STATE_ADDR;
    wire logic set_wr  = take_wr && two && req_addr_i == CURRENT_SETPOINT_ADDR;
    wire logic max_ok  = req_data_i <= SETPOINT_MAX;

    // reset must be visible, so this one is never disabled
    property p_reset_local;
        disable iff (1'b0) !resetn_i |=> !remote_active_o && current_limit_o == 16'h0000;
    endproperty
    property p_refuse;
        rem_wr && req_data_i == REMOTE_ENTER_CODE && remote_refuse_i && !remote_active_o
        |=> !remote_active_o && !wr_accepted_o;
    endproperty
    property p_enter;
        rem_wr && req_data_i == REMOTE_ENTER_CODE && !remote_refuse_i
        |=> remote_active_o && wr_accepted_o;
    endproperty
    property p_leave;
        rem_wr && req_data_i == REMOTE_LEAVE_CODE |=> !remote_active_o;
    endproperty
    property p_local_hold;
        set_wr && !remote_active_o |=> $stable(current_limit_o) && !wr_accepted_o;
    endproperty
    property p_setpoint;
        set_wr && remote_active_o && max_ok
        |=> current_limit_o == $past(req_data_i) && wr_accepted_o;
    endproperty
    property p_over_range;
        set_wr && !max_ok |=> $stable(current_limit_o) && !wr_accepted_o;
    endproperty
    property p_bad_length;
        take_wr && !two |=> !wr_accepted_o;
    endproperty
    property p_read_latency;
        take_rd |=> !rd_valid_o ##1 rd_valid_o;
    endproperty
    // snapshot at the taking edge, words two to four edges later
    property p_triplet;
        take_rd && req_addr_i == MEASURED_VOLTAGE_ADDR
            && record_length_i == LEN_W'(6)
        |=> ##1 rd_data_o == $past(meas_voltage_i, 2)
        ##1 rd_data_o == $past(meas_current_i, 3)
        ##1 rd_data_o == $past(meas_power_i, 4) && rd_last_o;
    endproperty
    a_reset_local: assert property (p_reset_local) else $error("not local after reset");
    a_refuse: assert property (p_refuse) else $error("refused entry took effect");
    a_enter: assert property (p_enter) else $error("remote entry failed");
    a_leave: assert property (p_leave) else $error("remote leave failed");
    a_local_hold: assert property (p_local_hold) else $error("local write applied");
    a_setpoint: assert property (p_setpoint) else $error("set current not applied");
    a_over_range: assert property (p_over_range) else $error("over range applied");
    a_bad_length: assert property (p_bad_length) else $error("bad length accepted");
    a_read_latency: assert property (p_read_latency) else $error("read latency wrong");
    a_triplet: assert property (p_triplet) else $error("triplet order wrong");
    c_enter: cover property (p_enter);
    c_setpoint: cover property (set_wr && remote_active_o && max_ok);
    c_triplet: cover property (take_rd && record_length_i == LEN_W'(6));
endmodule

bind fieldbus_record_access record_access_chk #(.LEN_W(LEN_W)) chk_inst (
    .clock_i(clock_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i),
    .req_write_i(req_write_i), .req_addr_i(req_addr_i),
    .record_length_i(record_length_i), .req_data_i(req_data_i),
    .req_ready_o(req_ready_o), .wr_accepted_o(wr_accepted_o),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .rd_last_o(rd_last_o),
    .remote_refuse_i(remote_refuse_i), .meas_voltage_i(meas_voltage_i),
    .meas_current_i(meas_current_i), .meas_power_i(meas_power_i),
    .remote_active_o(remote_active_o), .current_limit_o(current_limit_o));

// File: testbench/record_master.sv
// model of the fieldbus master issuing record requests
`timescale 1ns/10ps
module record_master (
    input  wire logic        clock_i,
    input  wire logic        req_ready_i,
    output logic             req_valid_o,
    output logic             req_write_o,
    output logic [15:0]      req_addr_o,
    output logic [7:0]       record_length_o,
    output logic [15:0]      req_data_o
);
    int gap = 0;
    initial begin
        req_valid_o = 1'b0;
        req_write_o = 1'b0;
        req_addr_o = 16'h0000;
        record_length_o = 8'h00;
        req_data_o = 16'h0000;
    end
    // hold the request until ready is seen at an edge; slow when gap > 0
    task send(input logic w, input logic [15:0] a, input logic [7:0] l,
              input logic [15:0] d);
        repeat (gap + 1) @(posedge clock_i);
        #1;
        req_valid_o = 1'b1;
        req_write_o = w;
        req_addr_o = a;
        record_length_o = l;
        req_data_o = d;
        while (req_ready_i !== 1'b1) begin
            @(posedge clock_i);
            #1;
        end
        @(posedge clock_i);
        #1;
        // released address and data lines flip so stale values are never mistaken
        req_valid_o = 1'b0;
        req_addr_o = ~a;
        req_data_o = ~d;
    endtask
endmodule

// File: testbench/fieldbus_record_access_tb.sv
// self-checking bench for the record access block
`timescale 1ns/10ps
module fieldbus_record_access_tb;
    import fieldbus_record_pkg::*;
    logic        clock_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        valid, write, ready, wr_done, wr_acc, rd_valid, rd_last;
    logic        refuse = 1'b0;
    logic        remote, unm;
    logic [15:0] addr, data, rd_data, limit;
    logic [7:0]  len;
    logic [15:0] v = 16'h263a, c = 16'h0c9b, p = 16'h0925;
    int          n_errors = 0;
    int          checks_done = 0;

    always #5 clock_i = ~clock_i;
    fieldbus_record_access fieldbus_record_access_inst (
        .clock_i(clock_i), .resetn_i(resetn_i), .req_valid_i(valid),
        .req_write_i(write), .req_addr_i(addr), .record_length_i(len),
        .req_data_i(data), .req_ready_o(ready), .wr_done_o(wr_done),
        .wr_accepted_o(wr_acc), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
        .rd_last_o(rd_last), .rd_unmapped_o(unm), .remote_refuse_i(refuse),
        .meas_voltage_i(v), .meas_current_i(c), .meas_power_i(p),
        .remote_active_o(remote), .current_limit_o(limit));
    record_master record_master_inst (
        .clock_i(clock_i), .req_ready_i(ready), .req_valid_o(valid),
        .req_write_o(write), .req_addr_o(addr), .record_length_o(len),
        .req_data_o(data));

    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // answer pulses stand in the cycle after the taking edge
    task wr(input logic [15:0] a, input logic [7:0] l, input logic [15:0] d,
            input logic acc);
        record_master_inst.send(1'b1, a, l, d);
        chk("wr_done", 16'h0001, {15'h0000, wr_done});
        chk("wr_accepted", {15'h0000, acc}, {15'h0000, wr_acc});
    endtask
    task rd(input logic [15:0] a, input logic [7:0] l, input int n,
            input logic [47:0] ev);
        record_master_inst.send(1'b0, a, l, 16'h0000);
        chk("rd_valid early", 16'h0000, {15'h0000, rd_valid});
        for (int i = 0; i < n; i++) begin
            @(posedge clock_i);
            #1;
            chk("rd_valid", 16'h0001, {15'h0000, rd_valid});
            chk("rd_data", ev[47-16*i -: 16], rd_data);
            chk("rd_last", {15'h0000, i == n - 1}, {15'h0000, rd_last});
        end
    endtask

    initial begin
        repeat (6) @(posedge clock_i);
        #1;
        resetn_i = 1'b1;
        chk("remote", 16'h0000, {15'h0000, remote});
        chk("limit", 16'h0000, limit);
        wr(CURRENT_SETPOINT_ADDR, 8'h02, 16'h0c0c, 1'b0);
        chk("limit", 16'h0000, limit);
        rd(CURRENT_SETPOINT_ADDR, 8'h02, 1, 48'h0);
        rd(REMOTE_STATE_ADDR, 8'h02, 1, 48'h0);
        $display("local control test ended");
        refuse = 1'b1;
        wr(REMOTE_STATE_ADDR, 8'h02, 16'hff00, 1'b0);
        chk("remote", 16'h0000, {15'h0000, remote});
        refuse = 1'b0;
        wr(REMOTE_STATE_ADDR, 8'h02, 16'hff00, 1'b1);
        chk("remote", 16'h0001, {15'h0000, remote});
        $display("remote entry test ended");
        wr(CURRENT_SETPOINT_ADDR, 8'h02, 16'h0c0c, 1'b1);
        chk("limit", 16'h0c0c, limit);
        wr(CURRENT_SETPOINT_ADDR, 8'h02, 16'hcccc, 1'b1);
        wr(CURRENT_SETPOINT_ADDR, 8'h02, 16'hcccd, 1'b0);
        wr(CURRENT_SETPOINT_ADDR, 8'h04, 16'h0001, 1'b0);
        chk("limit", 16'hcccc, limit);
        rd(CURRENT_SETPOINT_ADDR, 8'h02, 1, {16'hcccc, 32'h0});
        $display("set current test ended");
        record_master_inst.gap = 2;
        rd(MEASURED_VOLTAGE_ADDR, 8'h06, 3, {v, c, p});
        chk("rd_unmapped", 16'h0000, {15'h0000, unm});
        rd(MEASURED_VOLTAGE_ADDR, 8'h04, 2, {v, c, 16'h0});
        rd(16'h0300, 8'h02, 1, 48'h0);
        chk("rd_unmapped", 16'h0001, {15'h0000, unm});
        record_master_inst.gap = 0;
        $display("multi register read test ended");
        wr(REMOTE_STATE_ADDR, 8'h02, 16'h0000, 1'b1);
        chk("remote", 16'h0000, {15'h0000, remote});
        wr(CURRENT_SETPOINT_ADDR, 8'h02, 16'h0001, 1'b0);
        chk("limit", 16'hcccc, limit);
        $display("remote leave test ended");
        report_and_stop;
    end
    // whole run needs well under 200 cycles; allow ten times that
    initial begin
        #20000;
        n_errors++;
        report_and_stop;
    end
endmodule
